// ===== hdl/itsm_timer.sv
`timescale 1ns/1ps
// Functional notes
// - Every cycle belongs to one of six classes
// - Total equals sum of count times cost
// - On-chip access two states, internal one
// - Supporting module costs by path width
// - 8-bit external bus costs with waits
// - 16-bit external bus costs with waits
// - Bit-set: two fetches, two byte accesses
module itsm_timer import itsm_pkg::*; (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic start,
  input wire itsm_instr_e instr_sel,
  input wire logic [ITSM_CNT_W-1:0] cnt_fetch,
  input wire logic [ITSM_CNT_W-1:0] cnt_branch,
  input wire logic [ITSM_CNT_W-1:0] cnt_stack,
  input wire logic [ITSM_CNT_W-1:0] cnt_byte,
  input wire logic [ITSM_CNT_W-1:0] cnt_word,
  input wire logic [ITSM_CNT_W-1:0] cnt_intop,
  input wire itsm_tgt_e tgt_fetch,
  input wire itsm_tgt_e tgt_branch,
  input wire itsm_tgt_e tgt_stack,
  input wire itsm_tgt_e tgt_data,
  input wire logic [ITSM_WAIT_W-1:0] wait_m,
  output logic busy_q,
  output logic done_q,
  output logic [ITSM_TOT_W-1:0] total_q,
  output logic [ITSM_TOT_W-1:0] elapsed_q,
  output logic [2:0] cls_q
);
  itsm_state_e state_q;
  logic [ITSM_CNT_W-1:0] cnt_q [ITSM_NCLS];
  itsm_tgt_e tgt_q [4];
  logic [ITSM_WAIT_W-1:0] wait_q;
  logic [ITSM_COST_W-1:0] cost_w [ITSM_NCLS];
  logic [ITSM_NCLS-1:0] nz;
  logic [ITSM_CNT_W-1:0] rem_q;
  logic [ITSM_COST_W-1:0] st_q;
  logic [ITSM_TOT_W-1:0] sum_d;
  logic [2:0] first_cls;
  logic [2:0] next_cls_w;
  logic last_state;
  logic [ITSM_COST_W-1:0] cur_cost;

  // Lowest class at or above from that still has cycles to run
  function automatic logic [2:0] next_cls(input logic [2:0] from,
                                          input logic [ITSM_NCLS-1:0] live);
    next_cls = ITSM_CLS_NONE;
    for (int k = ITSM_NCLS - 1; k >= 0; k--) begin
      if (3'(k) >= from && live[k]) begin
        next_cls = 3'(k);
      end
    end
  endfunction : next_cls

  // One cost lookup per class; fetch, branch and stack use their own targets, byte, word and internal share the data target
  for (genvar g = 0; g < ITSM_NCLS; g++) begin : g_cls
    itsm_cost u_cost (
      .cls(itsm_cls_e'(3'(g))),
      .tgt(tgt_q[(g < 3) ? g : 3]),
      .wait_m(wait_q),
      .cost(cost_w[g])
    );
    assign nz[g] = |cnt_q[g];
  end

  // Weighted sum of all classes
  always_comb begin
    sum_d = '0;
    for (int k = 0; k < ITSM_NCLS; k++) begin
      sum_d = sum_d + ITSM_TOT_W'(cnt_q[k]) * ITSM_TOT_W'(cost_w[k]);
    end
  end

  assign first_cls = next_cls(3'h0, nz);
  assign next_cls_w = next_cls(cls_q + 3'h1, nz);
  assign cur_cost = cost_w[(cls_q < 3'(ITSM_NCLS)) ? cls_q : 3'h0];
  assign last_state = (st_q == cur_cost - 5'h01);

  // Latch counts and targets at start so the walk sees a stable profile
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int k = 0; k < ITSM_NCLS; k++) cnt_q[k] <= '0;
      for (int k = 0; k < 4; k++) tgt_q[k] <= TGT_ONCHIP;
      wait_q <= '0;
    end else if (start && state_q == ST_IDLE) begin
      unique case (instr_sel)
        INSTR_BIT_SET: begin
          cnt_q <= '{BITSET_FETCH_CNT, 4'h0, 4'h0, BITSET_BYTE_CNT, 4'h0, 4'h0};
        end
        INSTR_SUBR_JUMP: begin
          cnt_q <= '{SUBJ_FETCH_CNT, SUBJ_BRANCH_CNT, SUBJ_STACK_CNT, 4'h0, 4'h0, 4'h0};
        end
        default: begin
          cnt_q <= '{cnt_fetch, cnt_branch, cnt_stack, cnt_byte, cnt_word, cnt_intop};
        end
      endcase
      tgt_q <= '{tgt_fetch, tgt_branch, tgt_stack, tgt_data};
      wait_q <= wait_m;
    end
  end

  // Sequencer: idle, one cycle to form the total, then one clock per state
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      cls_q <= ITSM_CLS_NONE;
      rem_q <= '0;
      st_q <= '0;
      done_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q <= ST_CALC;
            busy_q <= 1'b1;
          end
        end
        ST_CALC: begin
          st_q <= '0;
          cls_q <= first_cls;
          rem_q <= cnt_q[(first_cls < 3'(ITSM_NCLS)) ? first_cls : 3'h0];
          if (first_cls == ITSM_CLS_NONE) begin
            state_q <= ST_IDLE; // Empty profile ends at once
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end else begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!last_state) begin
            st_q <= st_q + 5'h01;
          end else begin
            st_q <= '0;
            if (rem_q != 4'h1) begin
              rem_q <= rem_q - 4'h1;
            end else if (next_cls_w == ITSM_CLS_NONE) begin
              state_q <= ST_IDLE;
              cls_q <= ITSM_CLS_NONE;
              busy_q <= 1'b0;
              done_q <= 1'b1;
            end else begin
              cls_q <= next_cls_w;
              rem_q <= cnt_q[next_cls_w];
            end
          end
        end
        default: state_q <= ST_IDLE; // Code 3 never used
      endcase
    end
  end

  // Total is formed once per instruction and held until the next start
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      total_q <= '0;
    end else if (state_q == ST_CALC) begin
      total_q <= sum_d;
    end
  end

  // Elapsed states, cleared on start, one per clock while walking
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      elapsed_q <= '0;
    end else if (state_q == ST_IDLE && start) begin
      elapsed_q <= '0;
    end else if (state_q == ST_RUN) begin
      elapsed_q <= elapsed_q + 12'h001;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence start_seq;
    state_q == ST_IDLE && start;
  endsequence
  sequence calc_seq;
    state_q == ST_CALC && !done_q;
  endsequence
  sequence run_seq;
    state_q == ST_RUN;
  endsequence

  start_walk_a: assert property (start_seq |=> calc_seq ##1 (state_q == ST_RUN || done_q))
    else $error("start did not lead to calc then run");
  done_total_a: assert property (done_q |-> elapsed_q == total_q)
    else $error("elapsed states differ from computed total");
  class_valid_a: assert property (state_q == ST_RUN |-> cls_q < 3'(ITSM_NCLS) && nz[cls_q])
    else $error("walk on an invalid or empty class");
  onchip_cost_a: assert property (tgt_q[0] == TGT_ONCHIP |-> cost_w[0] == 5'h02)
    else $error("on-chip fetch cost wrong");
  intop_cost_a: assert property (cost_w[5] == 5'h01)
    else $error("internal operation cost wrong");
  sup_cost_a: assert property (tgt_q[3] == TGT_SUP8 |-> cost_w[3] == 5'h03 && cost_w[4] == 5'h06)
    else $error("8-bit supporting module cost wrong");
  ext8_cost_a: assert property (tgt_q[3] == TGT_EXT8_3 |->
      cost_w[4] == 5'h06 + {1'b0, wait_q, 1'b0} && cost_w[3] == 5'h03 + {2'h0, wait_q})
    else $error("8-bit external three-state cost wrong");
  ext16_cost_a: assert property (tgt_q[2] == TGT_EXT16_3 |-> cost_w[2] == 5'h03 + {2'h0, wait_q})
    else $error("16-bit external three-state cost wrong");
  bitset_prof_a: assert property ((start_seq and instr_sel == INSTR_BIT_SET) |=>
      cnt_q[0] == 4'h2 && cnt_q[3] == 4'h2 && !nz[1] && !nz[2] && !nz[4] && !nz[5])
    else $error("bit-set profile wrong");
  subj_prof_a: assert property ((start_seq and instr_sel == INSTR_SUBR_JUMP) |=>
      cnt_q[0] == 4'h2 && cnt_q[1] == 4'h2 && cnt_q[2] == 4'h2 && nz[5:3] == 3'h0)
    else $error("subroutine jump profile wrong");
  done_pulse_a: assert property (done_q |=> !done_q)
    else $error("done held longer than one cycle");
  done_idle_a: assert property (done_q |-> !busy_q && cls_q == ITSM_CLS_NONE)
    else $error("outputs not idle at done");
  elapsed_step_a: assert property (run_seq |=> elapsed_q == $past(elapsed_q) + 12'h001)
    else $error("elapsed did not advance during walk");
  walk_hold_a: assert property ((run_seq and !last_state) |=>
      state_q == ST_RUN && !done_q)
    else $error("walk ended before the last state of a cycle");
endmodule : itsm_timer

// ===== hdl/itsm_pkg.sv
package itsm_pkg;
  // Widths of counts, per-cycle costs, wait field and totals
  localparam int ITSM_NCLS = 6;
  localparam int ITSM_CNT_W = 4;
  localparam int ITSM_COST_W = 5;
  localparam int ITSM_WAIT_W = 3;
  localparam int ITSM_TOT_W = 12;

  // Cycle classes, walked in this order during an instruction
  typedef enum logic [2:0] {
    CLS_FETCH = 3'h0,
    CLS_BRANCH = 3'h1,
    CLS_STACK = 3'h2,
    CLS_BYTE = 3'h3,
    CLS_WORD = 3'h4,
    CLS_INTOP = 3'h5
  } itsm_cls_e;

  localparam logic [2:0] ITSM_CLS_NONE = 3'h6;

  // Access targets
  typedef enum logic [2:0] {
    TGT_ONCHIP = 3'h0,
    TGT_SUP8 = 3'h1,
    TGT_SUP16 = 3'h2,
    TGT_EXT8_2 = 3'h3,
    TGT_EXT8_3 = 3'h4,
    TGT_EXT16_2 = 3'h5,
    TGT_EXT16_3 = 3'h6
  } itsm_tgt_e;

  // Instruction selection: explicit counts or a built-in profile
  typedef enum logic [1:0] {
    INSTR_CUSTOM = 2'h0,
    INSTR_BIT_SET = 2'h1,
    INSTR_SUBR_JUMP = 2'h2
  } itsm_instr_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CALC = 2'h1,
    ST_RUN = 2'h2
  } itsm_state_e;

  // States per cycle
  localparam logic [4:0] COST_ONCHIP = 5'h02;
  localparam logic [4:0] COST_INTERNAL = 5'h01;
  localparam logic [4:0] COST_SUP8_BYTE = 5'h03;
  localparam logic [4:0] COST_SUP8_WORD = 5'h06;
  localparam logic [4:0] COST_SUP16 = 5'h03;
  localparam logic [4:0] COST_EXT8_2_BYTE = 5'h02;
  localparam logic [4:0] COST_EXT8_2_WORD = 5'h04;
  localparam logic [4:0] COST_EXT8_3_BYTE = 5'h03;
  localparam logic [4:0] COST_EXT8_3_WORD = 5'h06;
  localparam logic [4:0] COST_EXT16_2 = 5'h02;
  localparam logic [4:0] COST_EXT16_3 = 5'h03;

  // Built-in instruction profiles
  localparam logic [3:0] BITSET_FETCH_CNT = 4'h2;
  localparam logic [3:0] BITSET_BYTE_CNT = 4'h2;
  localparam logic [3:0] SUBJ_FETCH_CNT = 4'h2;
  localparam logic [3:0] SUBJ_BRANCH_CNT = 4'h2;
  localparam logic [3:0] SUBJ_STACK_CNT = 4'h2;
endpackage : itsm_pkg

// ===== hdl/itsm_cost.sv
`timescale 1ns/1ps
// States taken by one cycle of a class on a target
module itsm_cost import itsm_pkg::*; (
  input wire itsm_cls_e cls,
  input wire itsm_tgt_e tgt,
  input wire logic [ITSM_WAIT_W-1:0] wait_m,
  output logic [ITSM_COST_W-1:0] cost
);
  logic [ITSM_COST_W-1:0] m1;
  logic [ITSM_COST_W-1:0] m2;
  logic narrow;

  assign m1 = {2'h0, wait_m};
  assign m2 = {1'b0, wait_m, 1'b0};
  // Only byte data fits one 8-bit transfer; branch and stack reads are word wide
  assign narrow = (cls == CLS_BYTE);

  // Cost table
  always_comb begin
    cost = COST_ONCHIP;
    if (cls == CLS_INTOP) begin
      cost = COST_INTERNAL;
    end else begin
      unique case (tgt)
        TGT_ONCHIP: cost = COST_ONCHIP;
        TGT_SUP8: cost = narrow ? COST_SUP8_BYTE : COST_SUP8_WORD;
        TGT_SUP16: cost = COST_SUP16;
        TGT_EXT8_2: cost = narrow ? COST_EXT8_2_BYTE : COST_EXT8_2_WORD;
        TGT_EXT8_3: cost = narrow ? COST_EXT8_3_BYTE + m1 : COST_EXT8_3_WORD + m2;
        TGT_EXT16_2: cost = COST_EXT16_2;
        TGT_EXT16_3: cost = COST_EXT16_3 + m1;
        default: cost = COST_ONCHIP; // Code 7 unused, treated as on-chip
      endcase
    end
  end
endmodule : itsm_cost

// ===== test/itsm_ext_dev.sv
`timescale 1ns/1ps
// External device model: supplies the inserted wait count for one instruction
module itsm_ext_dev import itsm_pkg::*; (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic load,
  input wire logic [ITSM_WAIT_W-1:0] m_in,
  output logic [ITSM_WAIT_W-1:0] wait_m
);
  logic [ITSM_WAIT_W-1:0] held_q;

  // Held between loads so the waits cannot drift in mid-instruction
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      held_q <= 3'h0;
    end else if (load) begin
      held_q <= m_in;
    end
  end

  // New setting shows at once, so the accepting edge already sees it
  assign wait_m = load ? m_in : held_q;
endmodule : itsm_ext_dev

// ===== test/itsm_timer_tb.sv
`timescale 1ns/1ps
module itsm_timer_tb import itsm_pkg::*;;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic start = 1'b0;
  logic load = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [3:0] cnt [6] = '{default: 4'h0};
  logic [2:0] tgt [4] = '{default: 3'h0};
  logic [2:0] m_in = 3'h0;
  logic [2:0] wait_m;
  logic busy_q;
  logic done_q;
  logic [11:0] total_q;
  logic [11:0] elapsed_q;
  logic [2:0] cls_q;
  int seed = 13;
  int fail_count = 0;
  int samples_checked = 0;
  int c [6];
  int t [4];

  // One state per clock at 25 MHz
  always #20 sys_clk = ~sys_clk;

  itsm_ext_dev itsm_ext_dev_i (.sys_clk(sys_clk), .resetn(resetn), .load(load),
    .m_in(m_in), .wait_m(wait_m));

  itsm_timer itsm_timer_i (.sys_clk(sys_clk), .resetn(resetn), .start(start),
    .instr_sel(itsm_instr_e'(sel)), .cnt_fetch(cnt[0]), .cnt_branch(cnt[1]),
    .cnt_stack(cnt[2]), .cnt_byte(cnt[3]), .cnt_word(cnt[4]), .cnt_intop(cnt[5]),
    .tgt_fetch(itsm_tgt_e'(tgt[0])), .tgt_branch(itsm_tgt_e'(tgt[1])),
    .tgt_stack(itsm_tgt_e'(tgt[2])), .tgt_data(itsm_tgt_e'(tgt[3])),
    .wait_m(wait_m), .busy_q(busy_q), .done_q(done_q), .total_q(total_q),
    .elapsed_q(elapsed_q), .cls_q(cls_q));

  // Cost of one cycle of class k on target code tc with m waits
  function automatic int cst(int k, int tc, int m);
    if (k == 5) return 1;
    case (tc)
      1: return (k == 3) ? 3 : 6;
      2: return 3;
      3: return (k == 3) ? 2 : 4;
      4: return (k == 3) ? 3 + m : 6 + 2 * m;
      5: return 2;
      6: return 3 + m;
      default: return 2;
    endcase
  endfunction : cst

  task automatic check(string what, logic [11:0] exp, logic [11:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check

  // Every output must read idle while reset is held
  task automatic check_idle();
    check("reset busy", 12'h000, 12'(busy_q));
    check("reset done", 12'h000, 12'(done_q));
    check("reset class", 12'(ITSM_CLS_NONE), 12'(cls_q));
    check("reset total", 12'h000, total_q);
    check("reset elapsed", 12'h000, elapsed_q);
  endtask : check_idle

  task automatic print_verdict();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  // Issues one instruction, scribbles refused starts while busy, checks the outcome
  task automatic run(int s, int cc [6], int tt [4], int m);
    int ec [6];
    int hist [8];
    int n;
    int tot;
    ec = cc;
    if (s == 1) ec = '{2, 0, 0, 2, 0, 0};
    if (s == 2) ec = '{2, 2, 2, 0, 0, 0};
    hist = '{default: 0};
    n = 0;
    tot = 0;
    for (int k = 0; k < 6; k++) tot += ec[k] * cst(k, tt[k < 3 ? k : 3], m);
    sel = s[1:0];
    start = 1'b1;
    load = 1'b1;
    m_in = m[2:0];
    for (int k = 0; k < 6; k++) cnt[k] = cc[k][3:0];
    for (int k = 0; k < 4; k++) tgt[k] = tt[k][2:0];
    @(negedge sys_clk);
    start = 1'b0;
    load = 1'b0;
    check("calc busy", 12'h001, 12'(busy_q));
    check("calc elapsed", 12'h000, elapsed_q);
    while (done_q !== 1'b1 && n < 4000) begin
      @(negedge sys_clk);
      n++;
      if (done_q !== 1'b1) begin
        hist[cls_q]++;
        check("busy", 12'h001, 12'(busy_q));
        start = 1'($random(seed));
        cnt[0] = 4'($random(seed));
      end
    end
    check("idle busy", 12'h000, 12'(busy_q));
    check("idle class", 12'(ITSM_CLS_NONE), 12'(cls_q));
    check("cycles", 12'(tot + 1), 12'(n));
    check("total", 12'(tot), total_q);
    check("elapsed", 12'(tot), elapsed_q);
    for (int k = 0; k < 6; k++) begin
      check("class", 12'(ec[k] * cst(k, tt[k < 3 ? k : 3], m)), 12'(hist[k]));
    end
    check("none", 12'h000, 12'(hist[6] + hist[7]));
    if (n >= 4000) begin
      check("timeout", 12'h000, 12'h001);
      print_verdict();
    end
  endtask : run

  // Corner cases first, then random instructions back to back
  initial begin
    repeat (20) @(negedge sys_clk);
    check_idle();
    resetn = 1'b1;
    run(1, '{9, 9, 9, 9, 9, 9}, '{6, 0, 0, 1}, 1);
    run(2, '{0, 0, 0, 0, 0, 0}, '{3, 3, 3, 0}, 0);
    run(0, '{0, 0, 0, 0, 0, 0}, '{0, 0, 0, 0}, 0);
    run(3, '{15, 15, 15, 15, 15, 15}, '{4, 4, 4, 4}, 7);
    // Reset in mid-walk must abandon the instruction and restart cleanly
    sel = 2'h3;
    start = 1'b1;
    for (int k = 0; k < 6; k++) cnt[k] = 4'hF;
    @(negedge sys_clk);
    start = 1'b0;
    repeat (6) @(negedge sys_clk);
    resetn = 1'b0;
    @(negedge sys_clk);
    check_idle();
    resetn = 1'b1;
    run(0, '{3, 2, 1, 4, 5, 6}, '{7, 2, 5, 1}, 0);
    repeat (40) begin
      for (int k = 0; k < 6; k++) c[k] = $random(seed) & 15;
      for (int k = 0; k < 4; k++) t[k] = $random(seed) & 7;
      run($random(seed) & 3, c, t, $random(seed) & 7);
    end
    start = 1'b0;
    print_verdict();
  end
endmodule : itsm_timer_tb
